// *** inc/ipsw_defines.svh ***
// Constants for the interrupt priority and standby wake controller.
// Assumes inclusion by bare name from the package and the design file.
`ifndef IPSW_DEFINES_SVH
`define IPSW_DEFINES_SVH
`define IPSW_NUM_SRC 41
`define IPSW_NUM_VEC 10
// Vector addresses, lowest first
`define IPSW_VEC_ADDR_0 17'h00003
`define IPSW_VEC_STEP 17'h00008
// Source index layout (bit positions in the source vector)
`define IPSW_SRC_EXT0 0
`define IPSW_SRC_EXT1 1
`define IPSW_SRC_EXT2 2
`define IPSW_SRC_T0L 3
`define IPSW_SRC_EXT4 4
`define IPSW_SRC_USB_BUS_ACT 5
`define IPSW_SRC_REMOTE 6
`define IPSW_SRC_EXT3 7
`define IPSW_SRC_EXT5 8
`define IPSW_SRC_BASE_TMR 9
`define IPSW_SRC_T0H 10
`define IPSW_SRC_EXT6 11
`define IPSW_SRC_USB_ATTACH 12
`define IPSW_SRC_USB_DETACH 13
`define IPSW_SRC_USB_RESUME 14
`define IPSW_SRC_PORT0 33
// Vector of each source, listed from source 40 down to source 0
`define IPSW_VEC_MAP {4'd9,4'd9,4'd9,4'd9,4'd9,4'd9,4'd9,4'd9, \
   4'd8,4'd8,4'd8,4'd8,4'd8,4'd8,4'd8, 4'd7,4'd7,4'd7,4'd7, 4'd6,4'd6, \
   4'd5,4'd5,4'd5,4'd5,4'd5, 4'd4,4'd4,4'd4,4'd4,4'd4, \
   4'd3,4'd3,4'd3, 4'd2,4'd2,4'd2,4'd2,4'd2, 4'd1, 4'd0}
`endif

// *** inc/ipsw_pkg.sv ***
// Types for the interrupt priority and standby wake controller.
// Assumes the defines header is on the include path.
package ipsw_pkg;
`include "ipsw_defines.svh"
   typedef enum logic [1:0] {LVL_NONE, LVL_L, LVL_H, LVL_X} ipsw_level_t;
   typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_HOLD, ST_XHOLD} ipsw_mode_t;
   // Request to the core: vector index, its address and level
   typedef struct packed {
      logic valid;
      logic [3:0] vec;
      logic [16:0] addr;
      ipsw_level_t level;
   } ipsw_req_t;
   // Clock and execution enables going to the rest of the chip
   typedef struct packed {
      logic cpu_run;
      logic periph_run;
      logic base_tmr_run;
      logic pll_run;
      logic ceramic_osc_run;
      logic rc_osc_run;
      logic xtal_osc_run;
   } ipsw_clk_ctl_t;
   typedef struct packed {
      ipsw_mode_t mode;
      logic [`IPSW_NUM_SRC-1:0] pend;
      ipsw_level_t [3:0] stack;
      logic [2:0] depth;
      ipsw_req_t req;
      ipsw_clk_ctl_t clk;
      logic xtal_keep;
      logic wdt_rst;
      logic wake;
   } ipsw_state_t;
endpackage

// *** src/ipsw_ctrl.sv ***
// Interrupt merge, priority and nesting logic plus standby mode control.
// Assumes one clock, synchronous inputs, and a core that acknowledges vectors.
`timescale 1ns/1ps
`include "ipsw_defines.svh"

module ipsw_ctrl
   import ipsw_pkg::*;
#(
   parameter int NUM_SRC = `IPSW_NUM_SRC,
   parameter int NUM_VEC = `IPSW_NUM_VEC
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic [NUM_SRC-1:0] SRC_IRQ_I, // One-cycle or level source events
   input wire logic [NUM_VEC-1:0] VEC_ENABLE_I, // Per-vector enable
   input wire logic [NUM_VEC-1:0] VEC_HIGH_I, // 1 selects X or H, 0 selects L
   input wire logic WDT_TIMEOUT_I,
   input wire logic WDT_AS_RESET_I, // 1: timeout resets, 0: timeout interrupts
   input wire logic IRQ_ACK_I, // Core takes the vector on OUT_REQ_O
   input wire logic RETI_I, // Core returns from the current service
   input wire logic HALT_CMD_I,
   input wire logic HOLD_CMD_I,
   input wire logic XHOLD_CMD_I,
   input wire logic XTAL_ON_I, // Crystal state before any hold
   output ipsw_req_t OUT_REQ_O,
   output ipsw_clk_ctl_t CLK_CTL_O,
   output ipsw_mode_t MODE_O,
   output logic WDT_SYS_RST_O,
   output logic WAKE_O
);
   // Per-source vector index, four bits each
   localparam logic [4*NUM_SRC-1:0] VMAP = `IPSW_VEC_MAP;
   ipsw_state_t s_q, s_d;

   // Vector-level request lines, merged from the sources
   logic [NUM_VEC-1:0] vec_req;
   logic [NUM_SRC-1:0] src_all;
   always_comb begin
      src_all = SRC_IRQ_I;
      // Watchdog as interrupt shares the top vector group
      if (!WDT_AS_RESET_I && WDT_TIMEOUT_I) begin
         src_all[NUM_SRC-1] = 1'b1;
      end
      vec_req = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (s_q.pend[i]) begin
            vec_req[VMAP[4*i +: 4]] = 1'b1;
         end
      end
   end

   // Wake terms; ext pins 0 and 1 assumed level-configured by software
   logic hold_wake, xhold_wake;
   always_comb begin
      hold_wake = src_all[`IPSW_SRC_EXT0] | src_all[`IPSW_SRC_EXT1]
         | src_all[`IPSW_SRC_EXT2] | src_all[`IPSW_SRC_EXT4] | src_all[`IPSW_SRC_EXT5]
         | src_all[`IPSW_SRC_PORT0] | src_all[`IPSW_SRC_USB_BUS_ACT];
      xhold_wake = hold_wake | src_all[`IPSW_SRC_BASE_TMR]
         | src_all[`IPSW_SRC_REMOTE];
   end

   // Arbitration: highest level, then lowest vector
   ipsw_level_t cur_lvl, best_lvl, lvl;
   logic [3:0] best_vec;
   logic [16:0] best_addr;
   always_comb begin
      // Level in service is the top of the nesting stack
      cur_lvl = (s_q.depth == 3'd0) ? LVL_NONE : s_q.stack[s_q.depth[1:0] - 2'd1];
      best_lvl = LVL_NONE;
      lvl = LVL_NONE;
      best_vec = '0;
      for (int v = 0; v < NUM_VEC; v++) begin
         if (!VEC_HIGH_I[v]) begin
            lvl = LVL_L;
         end else if (v < 2) begin
            lvl = LVL_X;
         end else begin
            lvl = LVL_H;
         end
         // Strict greater-than keeps lowest vector on ties
         if (vec_req[v] && VEC_ENABLE_I[v] && lvl > best_lvl) begin
            best_lvl = lvl;
            best_vec = 4'(v);
         end
      end
      // Vector addresses are evenly spaced from the first
      best_addr = `IPSW_VEC_ADDR_0 + 17'(best_vec) * `IPSW_VEC_STEP;
   end

   // Next state
   always_comb begin
      s_d = s_q;
      // Watchdog reset is echoed for one registered cycle
      s_d.wdt_rst = WDT_AS_RESET_I & WDT_TIMEOUT_I;
      s_d.wake = 1'b0;
      // Set wins over acknowledge-clear
      s_d.pend = s_q.pend | src_all;
      // Ack pushes the offered level and retires its vector's sources
      if (s_q.req.valid && IRQ_ACK_I) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            if (VMAP[4*i +: 4] == s_q.req.vec && !src_all[i]) begin
               s_d.pend[i] = 1'b0;
            end
         end
         s_d.stack[s_q.depth[1:0]] = s_q.req.level;
         s_d.depth = s_q.depth + 3'd1;
      end else if (RETI_I && s_q.depth != 3'd0) begin
         s_d.depth = s_q.depth - 3'd1;
      end
      // Offer only a strictly higher level; others wait pending
      s_d.req.valid = (best_lvl > cur_lvl) && !(s_q.req.valid && IRQ_ACK_I)
         && s_q.depth != 3'd4 && s_q.mode inside {ST_RUN, ST_HALT};
      // Request payload follows the arbitration winner
      s_d.req.vec = best_vec;
      s_d.req.addr = best_addr;
      s_d.req.level = best_lvl;
      // Standby entry from run only; each mode has its own exits
      unique case (s_q.mode)
         ST_RUN: begin
            if (HOLD_CMD_I) begin
               s_d.mode = ST_HOLD;
            end else if (XHOLD_CMD_I) begin
               s_d.mode = ST_XHOLD;
               s_d.xtal_keep = XTAL_ON_I;
            end else if (HALT_CMD_I) begin
               s_d.mode = ST_HALT;
            end
         end
         ST_HALT: begin
            if (s_q.req.valid && IRQ_ACK_I) begin
               s_d.mode = ST_RUN;
               s_d.wake = 1'b1;
            end
         end
         ST_HOLD: begin
            if (hold_wake) begin
               s_d.mode = ST_RUN;
               s_d.wake = 1'b1;
            end
         end
         ST_XHOLD: begin
            if (xhold_wake) begin
               s_d.mode = ST_RUN;
               s_d.wake = 1'b1;
            end
         end
      endcase
      // Watchdog reset leaves any standby mode
      if (s_d.wdt_rst) begin
         s_d.mode = ST_RUN;
         s_d.depth = '0;
         s_d.req.valid = 1'b0;
      end
      // No vector is offered while the core sleeps in a hold mode
      if (s_d.mode inside {ST_HOLD, ST_XHOLD}) begin
         s_d.req.valid = 1'b0;
      end
      // Clock enables follow the next mode
      s_d.clk = '{cpu_run: 1'b1, periph_run: 1'b1, base_tmr_run: 1'b1, pll_run: 1'b1,
         ceramic_osc_run: 1'b1, rc_osc_run: 1'b1, xtal_osc_run: XTAL_ON_I};
      unique case (s_d.mode)
         ST_RUN: begin
            // Run keeps every enable on except the crystal, which follows XTAL_ON_I
         end
         ST_HALT: begin
            s_d.clk.cpu_run = 1'b0;
         end
         ST_HOLD: begin
            s_d.clk = '0;
         end
         ST_XHOLD: begin
            s_d.clk = '0;
            s_d.clk.base_tmr_run = 1'b1;
            s_d.clk.xtal_osc_run = (s_q.mode == ST_XHOLD) ? s_q.xtal_keep
               : XTAL_ON_I;
         end
      endcase
   end

   // State register; reset pin returns to run with nothing pending
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         s_q <= '{
            mode: ST_RUN,
            pend: '0,
            stack: '{default: LVL_NONE},
            depth: '0,
            req: '0,
            clk: '{default: 1'b1},
            xtal_keep: 1'b1,
            wdt_rst: 1'b0,
            wake: 1'b0
         };
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register
   assign OUT_REQ_O = s_q.req;
   assign CLK_CTL_O = s_q.clk;
   assign MODE_O = s_q.mode;
   assign WDT_SYS_RST_O = s_q.wdt_rst;
   assign WAKE_O = s_q.wake;
endmodule // ipsw_ctrl

// *** tb/ipsw_ctrl_monitor.sv ***
// Checker for the interrupt priority and standby wake controller.
// Assumes binding onto ipsw_ctrl; sees its ports only.
`timescale 1ns/1ps
module ipsw_ctrl_monitor
   import ipsw_pkg::*;
#(
   parameter int NUM_SRC = 41
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic [NUM_SRC-1:0] SRC_IRQ_I,
   input wire logic IRQ_ACK_I,
   input wire logic WDT_TIMEOUT_I,
   input wire logic WDT_AS_RESET_I,
   input wire ipsw_req_t OUT_REQ_O,
   input wire ipsw_clk_ctl_t CLK_CTL_O,
   input wire ipsw_mode_t MODE_O,
   input wire logic WDT_SYS_RST_O,
   input wire logic WAKE_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   // Wake events met while a standby mode holds
   sequence s_hold_src;
      MODE_O == ST_HOLD && SRC_IRQ_I[2];
   endsequence
   sequence s_xhold_src;
      MODE_O == ST_XHOLD && SRC_IRQ_I[9];
   endsequence
   chk_vec_addr: assert property (OUT_REQ_O.valid |->
      OUT_REQ_O.addr == {10'h000, OUT_REQ_O.vec, 3'h3}) else $error("vector address off");
   chk_ack_drop: assert property (OUT_REQ_O.valid && IRQ_ACK_I |=>
      !OUT_REQ_O.valid) else $error("request stayed after ack");
   chk_wdt_reset: assert property (WDT_TIMEOUT_I && WDT_AS_RESET_I |=>
      WDT_SYS_RST_O) else $error("watchdog reset missing");
   chk_halt_clks: assert property (MODE_O == ST_HALT |->
      CLK_CTL_O[6:5] == 2'h1 && CLK_CTL_O[3:1] == 3'h7) else $error("halt enables wrong");
   chk_hold_clks: assert property (MODE_O == ST_HOLD |->
      CLK_CTL_O == 7'h00) else $error("hold enables wrong");
   chk_xhold_clks: assert property (MODE_O == ST_XHOLD |->
      CLK_CTL_O[6:1] == 6'h08) else $error("crystal hold enables wrong");
   chk_hold_wake: assert property (s_hold_src |-> ##[1:3] MODE_O == ST_RUN)
      else $error("hold not left");
   chk_xhold_wake: assert property (s_xhold_src |-> ##[1:3] MODE_O == ST_RUN)
      else $error("crystal hold not left");
   chk_wake_run: assert property (WAKE_O |->
      MODE_O == ST_RUN && $past(MODE_O) != ST_RUN) else $error("wake without mode exit");
endmodule // ipsw_ctrl_monitor

bind ipsw_ctrl ipsw_ctrl_monitor #(.NUM_SRC(NUM_SRC)) u_mon (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
   .SRC_IRQ_I(SRC_IRQ_I), .IRQ_ACK_I(IRQ_ACK_I), .WDT_TIMEOUT_I(WDT_TIMEOUT_I),
   .WDT_AS_RESET_I(WDT_AS_RESET_I), .OUT_REQ_O(OUT_REQ_O), .CLK_CTL_O(CLK_CTL_O),
   .MODE_O(MODE_O), .WDT_SYS_RST_O(WDT_SYS_RST_O), .WAKE_O(WAKE_O));

// *** tb/ipsw_core_model.sv ***
// Core stand-in: takes offered vectors after a chosen delay.
// Assumes the controller samples ack with a valid request.
`timescale 1ns/1ps
module ipsw_core_model
   import ipsw_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire ipsw_req_t req_i,
   input wire logic [1:0] dly_i,
   output logic ack_o,
   output logic got_o,
   output logic [3:0] vec_o
);
   logic [1:0] cnt_q;
   // Ack held until the taking edge, then dropped
   always_ff @(posedge clk_i) begin
      got_o <= rst_n_i && ack_o && req_i.valid;
      if (ack_o && req_i.valid) vec_o <= req_i.vec;
      if (!rst_n_i || !req_i.valid || ack_o) begin
         cnt_q <= 2'h0;
         ack_o <= 1'b0;
      end else if (cnt_q == dly_i) ack_o <= 1'b1;
      else cnt_q <= cnt_q + 2'h1;
   end
endmodule // ipsw_core_model

// *** tb/test_ipsw_ctrl.sv ***
// Self-checking bench for the interrupt and standby controller.
// Assumes the core model and the bound checker.
`timescale 1ns/1ps
module test_ipsw_ctrl;
   import ipsw_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, tmo = 1'b0, wsel = 1'b0, xtal = 1'b1;
   logic [40:0] src = '0;
   logic [3:0] cmd = '0; // Return, halt, hold, crystal hold
   logic [9:0] hi = 10'h021; // Vector 0 top level, vector 5 high
   logic [1:0] dly = 2'h0;
   logic ack, got, wrst, wake;
   logic [3:0] gvec;
   ipsw_req_t req;
   ipsw_clk_ctl_t cc;
   ipsw_mode_t mode;
   int failures = 0, checks = 0;
   int wakes = 0;
   ipsw_ctrl i_dut (.CLK_I(clk), .RST_N_I(rst_n), .SRC_IRQ_I(src), .VEC_ENABLE_I(10'h3ff),
      .VEC_HIGH_I(hi), .WDT_TIMEOUT_I(tmo), .WDT_AS_RESET_I(wsel), .IRQ_ACK_I(ack),
      .RETI_I(cmd[3]), .HALT_CMD_I(cmd[2]), .HOLD_CMD_I(cmd[1]), .XHOLD_CMD_I(cmd[0]),
      .XTAL_ON_I(xtal), .OUT_REQ_O(req), .CLK_CTL_O(cc), .MODE_O(mode),
      .WDT_SYS_RST_O(wrst), .WAKE_O(wake));
   ipsw_core_model i_core (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .dly_i(dly),
      .ack_o(ack), .got_o(got), .vec_o(gvec));
   always #25 clk = ~clk;
   // Count standby exits as the design reports them
   always @(negedge clk) begin
      if (wake === 1'b1) wakes++;
   end
   task automatic close_out;
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [16:0] g, input logic [16:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // One-cycle pulse on sources and commands
   task automatic fire(input logic [40:0] s, input logic [3:0] c);
      @(posedge clk);
      src <= s;
      cmd <= c;
      @(posedge clk);
      src <= '0;
      cmd <= '0;
   endtask
   // Bounded wait for the core to take a vector
   task automatic take(input logic [3:0] v, input logic ret);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (got !== 1'b1 && n < 40);
      chk(got, 1'b1);
      chk(gvec, v);
      if (ret) fire('0, 4'h8);
   endtask
   task automatic t_nest;
      dly <= 2'h3;
      fire(41'h4, 4'h0);
      take(4'h2, 1'b0);
      fire(41'h0_0010_0008, 4'h0);
      repeat (6) @(negedge clk);
      chk(req.valid, 1'b0);
      fire(41'h1, 4'h0);
      take(4'h0, 1'b1);
      fire('0, 4'h8);
      take(4'h2, 1'b1);
      take(4'h6, 1'b1);
   endtask
   task automatic t_wdt;
      fire('0, 4'h4);
      wsel <= 1'b1;
      tmo <= 1'b1;
      @(posedge clk) tmo <= 1'b0;
      @(negedge clk) chk(wrst, 1'b1);
      @(negedge clk) chk(mode, ST_RUN);
      @(posedge clk) {wsel, tmo} <= 2'h1;
      @(posedge clk) tmo <= 1'b0;
      take(4'h9, 1'b1);
   endtask
   // Enter a standby mode, check enables, wake it
   task automatic t_stby(input logic [3:0] c, input logic x, input logic [40:0] w,
      input logic [6:0] e, input logic [3:0] v);
      int w0;
      w0 = wakes;
      @(posedge clk) xtal <= x;
      fire('0, c);
      @(negedge clk) chk(cc, e);
      // Crystal hold must ignore a later crystal change
      if (c == 4'h1) begin
         @(posedge clk) xtal <= ~x;
         repeat (2) @(negedge clk);
         chk(cc, e);
      end
      fire(w, 4'h0);
      take(v, 1'b1);
      chk(mode, ST_RUN);
      chk(17'(wakes - w0), 17'h1);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      fire(41'h000_0400_8004, 4'h0);
      take(4'h5, 1'b1);
      take(4'h2, 1'b1);
      take(4'h8, 1'b1);
      t_nest;
      t_wdt;
      t_stby(4'h4, 1'b1, 41'h8000, 7'h3f, 4'h5);
      t_stby(4'h2, 1'b1, 41'h4, 7'h00, 4'h2);
      t_stby(4'h2, 1'b1, 41'h1, 7'h00, 4'h0);
      t_stby(4'h2, 1'b0, 41'h2_0000_0000, 7'h00, 4'h9);
      t_stby(4'h1, 1'b0, 41'h200, 7'h10, 4'h3);
      t_stby(4'h1, 1'b1, 41'h40, 7'h11, 4'h2);
      close_out;
   end
   // Hang guard well past the expected run
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      close_out;
   end
endmodule // test_ipsw_ctrl
